// >>> design/cki_pkg.sv
/*
  Package for the carkit event logic: register offsets, field positions,
  reset values, timing counts and the packed carrier types.
  Assumes a 10 MHz register clock.
*/
package cki_pkg;

  localparam logic [5:0] CKI_ENA_WR = 6'h1d;
  localparam logic [5:0] CKI_ENA_SET = 6'h1e;
  localparam logic [5:0] CKI_ENA_CLR = 6'h1f;
  localparam logic [5:0] CKI_STATE = 6'h20;
  localparam logic [5:0] CKI_CAPTURE = 6'h21;
  localparam logic [5:0] CKI_RID_WR = 6'h36;
  localparam logic [5:0] CKI_RID_SET = 6'h37;
  localparam logic [5:0] CKI_RID_CLR = 6'h38;
  localparam logic [5:0] CKI_IRQ_STAT = 6'h3c;
  localparam logic [5:0] CKI_IRQ_MASK = 6'h3d;

  // Writable bits of each register
  localparam logic [7:0] CKI_ENA_MASK = 8'h23;
  localparam logic [7:0] CKI_RID_MASK = 8'h70;
  localparam logic [7:0] CKI_IRQ_BITS = 8'h03;

  localparam int CKI_B_RISE = 0;
  localparam int CKI_B_FALL = 1;
  localparam int CKI_B_RIDEN = 5;
  localparam int CKI_S_OPEN = 0;
  localparam int CKI_S_CODE = 3;
  localparam int CKI_S_DONE = 6;
  localparam int CKI_L_OPEN = 0;
  localparam int CKI_L_RID = 3;
  localparam int CKI_V_DONE = 3;
  localparam int CKI_V_TRIG = 4;
  localparam int CKI_V_RSVD = 5;
  localparam int CKI_V_IEN = 6;

  localparam logic [7:0] CKI_RST8 = 8'h00;
  localparam logic [2:0] CKI_CODE_RST = 3'h0;

  localparam int CKI_CLK_KHZ = 10000;
  localparam int CKI_MEAS_US = 282;
  // Least time: round up
  localparam int CKI_MEAS_CYC = (CKI_MEAS_US * CKI_CLK_KHZ + 999) / 1000;
  localparam logic [11:0] CKI_MEAS_LAST = 12'(CKI_MEAS_CYC - 1);

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cki_bus_t;

  typedef enum {CKI_IDLE, CKI_MEAS} cki_meas_st_t;

endpackage

// >>> design/cki_edge.sv
/*
  Rise and fall detector for one level input.
  Assumes the input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module cki_edge (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Level in, edges out
  input wire logic level,
  output logic rise,
  output logic fall
);
  logic prev;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule

// >>> design/cki_meas.sv
/*
  Measurement timer: runs the fixed conversion time after a start and
  captures the converter code at its end.
  Assumes the code input is stable when the time runs out.
*/
`timescale 1ns/1ps
module cki_meas
  import cki_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic [2:0] code_in,
  output logic busy,
  output logic finish,
  output logic [2:0] code
);
  cki_meas_st_t state;
  logic [11:0] cnt;
  wire at_end = (state == CKI_MEAS) && (cnt == CKI_MEAS_LAST);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state <= CKI_IDLE;
      cnt <= 12'h000;
      code <= CKI_CODE_RST;
    end else begin
      case (state)
        CKI_IDLE: begin
          cnt <= 12'h000;
          if (start) begin
            state <= CKI_MEAS;
          end
        end
        CKI_MEAS: begin
          cnt <= cnt + 12'h001;
          if (at_end) begin
            state <= CKI_IDLE;
            code <= code_in;
          end
        end
        default: state <= CKI_IDLE;
      endcase
    end
  end

  assign busy = (state == CKI_MEAS);
  assign finish = at_end;
endmodule

// >>> design/cki_carkit_irq.sv
/*
  Carkit event logic: enable register with write/set/clear aliases,
  live state byte, read-to-clear capture byte, vendor resistor register,
  and the alternate interrupt to the receive command path.
  Assumes a single-cycle register port, read data one cycle later, and
  an ID floating level synchronous to ref_clk.
*/
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module cki_carkit_irq
  import cki_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog side
  input wire logic id_open,
  input wire logic [2:0] rid_code_in,
  output logic meas_active,
  // Receive command and interrupt
  output logic alt_int,
  output logic irq
);
  cki_bus_t bus;
  logic [7:0] ena;
  logic [7:0] capture;
  logic [7:0] rid_ctl;
  logic done;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  logic open_rise, open_fall;
  logic done_rise;
  logic meas_busy, meas_finish;
  logic [2:0] rid_code;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Address decode
  wire wr_ena = bus.wr && bus.addr == CKI_ENA_WR;
  wire set_ena = bus.wr && bus.addr == CKI_ENA_SET;
  wire clr_ena = bus.wr && bus.addr == CKI_ENA_CLR;
  wire wr_rid = bus.wr && bus.addr == CKI_RID_WR;
  wire set_rid = bus.wr && bus.addr == CKI_RID_SET;
  wire clr_rid = bus.wr && bus.addr == CKI_RID_CLR;
  wire wr_istat = bus.wr && bus.addr == CKI_IRQ_STAT;
  wire wr_imask = bus.wr && bus.addr == CKI_IRQ_MASK;
  wire rd_capture = bus.rd && bus.addr == CKI_CAPTURE;
  wire rd_rid = bus.rd &&
    (bus.addr == CKI_RID_WR || bus.addr == CKI_RID_SET ||
     bus.addr == CKI_RID_CLR);

  wire [7:0] wmask = bus.wdata & CKI_ENA_MASK;
  wire [7:0] next_ena = wr_ena ? wmask :
    set_ena ? (ena | wmask) :
    clr_ena ? (ena & ~wmask) : ena;

  wire [7:0] rmask = bus.wdata & CKI_RID_MASK;
  wire [7:0] rid_sw = wr_rid ? rmask :
    set_rid ? (rid_ctl | rmask) :
    clr_rid ? (rid_ctl & ~rmask) : rid_ctl;
  // Trigger rises only from a write or set with bit 4 high
  wire start_req = (wr_rid | set_rid) & rmask[CKI_V_TRIG];
  // Self-clear at the end beats a same-cycle software write
  wire [7:0] next_rid_ctl = meas_finish ?
    (rid_sw & ~(8'h01 << CKI_V_TRIG)) : rid_sw;

  // Effective resistor-done enable
  wire rid_en = ena[CKI_B_RIDEN] | rid_ctl[CKI_V_IEN];

  wire ev_open = (open_rise & ena[CKI_B_RISE]) |
    (open_fall & ena[CKI_B_FALL]);
  wire ev_rid = done_rise & rid_en;

  // Finish sets, and a same-cycle vendor read must not lose it
  wire next_done = meas_finish | (done & ~rd_rid);

  wire [7:0] cap_set = ({7'h00, ev_open} << CKI_L_OPEN) |
    ({7'h00, ev_rid} << CKI_L_RID);
  // Set wins over the clear-on-read
  wire [7:0] next_capture = cap_set | (rd_capture ? CKI_RST8 : capture);

  wire [7:0] ev_vec = {6'h00, ev_rid, ev_open};
  wire [7:0] next_irq_stat = (ev_vec | (irq_stat &
    ~(wr_istat ? bus.wdata : CKI_RST8))) & CKI_IRQ_BITS;

  wire [7:0] state_byte = ({7'h00, id_open} << CKI_S_OPEN) |
    ({5'h00, rid_code} << CKI_S_CODE) |
    ({7'h00, done} << CKI_S_DONE);
  wire [7:0] rid_byte = (rid_ctl & CKI_RID_MASK) |
    {4'h0, done, rid_code};

  logic [7:0] next_rdata;
  always_comb begin
    case (bus.addr)
      CKI_ENA_WR, CKI_ENA_SET, CKI_ENA_CLR: next_rdata = ena;
      CKI_STATE: next_rdata = state_byte;
      CKI_CAPTURE: next_rdata = capture;
      CKI_RID_WR, CKI_RID_SET, CKI_RID_CLR: next_rdata = rid_byte;
      CKI_IRQ_STAT: next_rdata = irq_stat;
      CKI_IRQ_MASK: next_rdata = irq_mask;
      default: next_rdata = CKI_RST8;
    endcase
  end

  cki_edge u_open_edge (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .level(id_open),
    .rise(open_rise),
    .fall(open_fall)
  );

  cki_edge u_done_edge (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .level(done),
    .rise(done_rise),
    .fall()
  );

  cki_meas u_meas (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(start_req),
    .code_in(rid_code_in),
    .busy(meas_busy),
    .finish(meas_finish),
    .code(rid_code)
  );

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ena <= CKI_RST8;
      capture <= CKI_RST8;
      rid_ctl <= CKI_RST8;
      done <= 1'b0;
      irq_stat <= CKI_RST8;
      irq_mask <= CKI_RST8;
      reg_rdata <= CKI_RST8;
    end else begin
      ena <= next_ena;
      capture <= next_capture;
      rid_ctl <= next_rid_ctl;
      done <= next_done;
      irq_stat <= next_irq_stat;
      if (wr_imask) begin
        irq_mask <= bus.wdata & CKI_IRQ_BITS;
      end
      reg_rdata <= bus.rd ? next_rdata : CKI_RST8;
    end
  end

  // Pending capture is shown in every receive command byte
  assign alt_int = |capture;
  assign irq = |(irq_stat & irq_mask);
  assign meas_active = meas_busy;
endmodule

// >>> dv/cki_carkit_irq_chk.sv
/*
  Checker for the carkit event logic.
  Assumes it is bound to the top, one clock.
*/
`timescale 1ns/1ps
module cki_carkit_irq_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Side signals
  input wire logic id_open,
  input wire logic meas_active,
  input wire logic alt_int
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [11:0] run_cyc;
  wire rd_ena = reg_rd && reg_addr == 6'h1d;
  wire rd_set = reg_rd && reg_addr == 6'h1e;
  wire rd_st = reg_rd && reg_addr == 6'h20;
  wire rd_cap = reg_rd && reg_addr == 6'h21;
  wire go = reg_wr && reg_addr[5:1] == 5'h1b && reg_wdata[4];
  always_ff @(posedge ref_clk)
    run_cyc <= nrst && meas_active ? run_cyc + 12'h001 : 12'h000;
  property p_alias; rd_ena ##1 rd_set |=> $stable(reg_rdata); endproperty
  a_alias: assert property (p_alias)
    else $error("enable aliases differ");
  property p_ena; rd_ena |=> (reg_rdata & 8'hdc) == 8'h00; endproperty
  a_ena: assert property (p_ena)
    else $error("enable stub bits set");
  property p_rsvd; rd_cap |=> reg_rdata[7:4] == 4'h0; endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("capture reserved bits set");
  property p_live;
    rd_st && $stable(id_open) |=> reg_rdata[0] == $past(id_open);
  endproperty
  a_live: assert property (p_live)
    else $error("float state wrong");
  property p_clr;
    rd_cap && $stable(id_open) && !meas_active && !$past(meas_active)
      && !$past(meas_active, 2) |=> !alt_int;
  endproperty
  a_clr: assert property (p_clr)
    else $error("capture kept after read");
  property p_alt; rd_cap |=> (|reg_rdata) == $past(alt_int); endproperty
  a_alt: assert property (p_alt)
    else $error("alt_int disagrees with capture");
  property p_len; $fell(meas_active) |-> run_cyc == 12'hb04; endproperty
  a_len: assert property (p_len)
    else $error("measurement length wrong");
  property p_go; go && !meas_active |-> ##[1:2] meas_active; endproperty
  a_go: assert property (p_go)
    else $error("trigger did not start");
  c_meas: cover property ($fell(meas_active));
  c_alt: cover property ($rose(alt_int));
  c_clr: cover property (rd_cap && alt_int);
endmodule
bind cki_carkit_irq cki_carkit_irq_chk u_chk (.ref_clk, .nrst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .id_open,
  .meas_active, .alt_int);

// >>> dv/cki_id_model.sv
/*
  Front end model: ID float sense and resistor converter.
  Assumes controls change right after a clock edge.
*/
`timescale 1ns/1ps
module cki_id_model (
  // Bench controls
  input wire logic pull_on,
  input wire logic float_req,
  input wire logic [2:0] code_req,
  // Block side
  input wire logic meas_active,
  output logic id_open,
  output logic [2:0] rid_code_in
);
  // Without the pull-up the pin never reads floating
  assign id_open = pull_on & float_req;
  // Code held only while converting
  assign rid_code_in = meas_active ? code_req : ~code_req;
endmodule

// >>> dv/tb_cki_carkit_irq.sv
/*
  Bench: register tasks, ID events, measurements, irq mask.
  Assumes the front end model and the bound checker.
*/
`timescale 1ns/1ps
module tb_cki_carkit_irq;
  logic ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic pull_on = 1'b0, float_req = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, en, reg_rdata;
  logic [2:0] code_req = 3'h0, rid_code_in;
  logic id_open, meas_active, alt_int, irq;
  int failures = 0, samples_checked = 0, cyc = 0, n;
  logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [5:0] rst_regs [6] = '{6'h1d, 6'h20, 6'h21, 6'h36, 6'h3c,
    6'h3d};
  cki_carkit_irq uut (.ref_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .id_open, .rid_code_in, .meas_active,
    .alt_int, .irq);
  cki_id_model far_end (.pull_on, .float_req, .code_req, .meas_active,
    .id_open, .rid_code_in);
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic acc(bit w, logic [5:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge ref_clk);
    if (!w) fork
      begin
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), d, reg_rdata);
      end
    join_none
  endtask
  task automatic idle(int k);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    foreach (rst_regs[i]) acc(0, rst_regs[i], 8'h00);
    acc(1, 6'h1d, 8'hff);
    acc(0, 6'h1d, 8'h23);
    acc(0, 6'h1e, 8'h23);
    acc(0, 6'h1f, 8'h23);
    acc(1, 6'h1f, 8'h21);
    acc(1, 6'h1e, 8'h01);
    acc(0, 6'h1d, 8'h03);
    acc(1, 6'h20, 8'hff);
    acc(1, 6'h2a, 8'hff);
    acc(0, 6'h2a, 8'h00);
    acc(0, 6'h20, 8'h00);
    acc(1, 6'h1f, 8'h02);
    pull_on <= 1'b1;
    float_req <= 1'b1;
    idle(3);
    chk("alt_int", 8'h01, alt_int);
    acc(0, 6'h20, 8'h01);
    acc(0, 6'h21, 8'h01);
    acc(0, 6'h21, 8'h00);
    float_req <= 1'b0;
    idle(3);
    acc(0, 6'h21, 8'h00);
    acc(1, 6'h1d, 8'h02);
    float_req <= 1'b1;
    idle(3);
    acc(0, 6'h21, 8'h00);
    float_req <= 1'b0;
    idle(3);
    acc(0, 6'h21, 8'h01);
    acc(1, 6'h3d, 8'h01);
    idle(2);
    chk("irq", 8'h01, irq);
    acc(1, 6'h3d, 8'h00);
    idle(2);
    chk("irq", 8'h00, irq);
    acc(1, 6'h3d, 8'h01);
    acc(1, 6'h3c, 8'h01);
    idle(2);
    chk("irq", 8'h00, irq);
    acc(1, 6'h1d, 8'h00);
    // Unmask the resistor event as well for the loop below
    acc(1, 6'h3d, 8'h03);
    for (int i = 0; i < 7; i++) begin
      en = (i % 3 == 2) ? 8'h40 : 8'h00;
      code_req <= codes[i];
      if (i % 3 == 1) acc(1, 6'h1e, 8'h20);
      acc(1, i % 2 ? 6'h36 : 6'h37, en | 8'h10);
      idle(2);
      chk("meas_active", 8'h01, meas_active);
      n = 0;
      while (meas_active === 1'b1 && n < 3000) begin
        @(posedge ref_clk);
        n++;
      end
      idle(3);
      chk("alt_int", i % 3 ? 8'h01 : 8'h00, alt_int);
      chk("irq", i % 3 ? 8'h01 : 8'h00, irq);
      acc(0, 6'h3c, i % 3 ? 8'h02 : 8'h00);
      acc(1, 6'h3c, 8'h02);
      acc(0, 6'h20, {2'b01, codes[i], 3'h0});
      acc(0, 6'h36, en | 8'h08 | codes[i]);
      acc(0, 6'h37, en | codes[i]);
      acc(0, 6'h20, {2'b00, codes[i], 3'h0});
      acc(0, 6'h21, i % 3 ? 8'h08 : 8'h00);
      acc(1, 6'h1f, 8'h20);
      acc(1, 6'h38, 8'h40);
    end
    idle(2);
    conclude();
  end
endmodule
